// [src/cvs_defines.svh]
`ifndef CVS_DEFINES_SVH
`define CVS_DEFINES_SVH

// ****************************************
// bus geometry and register offsets
// ****************************************
`define CVS_AW          8
`define CVS_OFF_COMM    8'h00
`define CVS_OFF_MODE    8'h04
`define CVS_OFF_STATUS  8'h08
`define CVS_OFF_DATA    8'h0c
`define CVS_RESP_OKAY   2'h0
`define CVS_RESP_SLVERR 2'h2

// ****************************************
// mode register fields and codes
// ****************************************
`define CVS_MODE_W      7
`define CVS_MODE_RST    7'h01
`define CVS_MD_IDLE     3'h0
`define CVS_MD_CONT     3'h1
`define CVS_MD_SINGLE   3'h2
`define CVS_MD_STANDBY  3'h3
`define CVS_STAT_W      4
`define CVS_DATA_W      24
`define CVS_DATA_RST    24'h000000

// ****************************************
// timing
// ****************************************
`define CVS_CLK_MHZ     25
`define CVS_SETTLE_US   20
`define CVS_UPDATE_US   4
`define CVS_SETTLE_CYC  ((`CVS_SETTLE_US * `CVS_CLK_MHZ + 0) / 1)
`define CVS_UPDATE_CYC  ((`CVS_UPDATE_US * `CVS_CLK_MHZ + 0) / 1)
`define CVS_CNT_W       12

`endif

// [src/cvs_pkg.sv]
// ****************************************
// shared types
// ****************************************
package cvs_pkg;

    // mode register layout, low bits first from the bottom
    typedef struct packed {
        logic       port_out_bit1;
        logic       port_out_bit0;
        logic       port_output_enable;
        logic       quick_settle;
        logic [2:0] op_mode;
    } cvs_mode_s;

    // status register layout
    typedef struct packed {
        logic in_reset;
        logic standby_flag;
        logic filter_settled_n;
        logic ready_n;
    } cvs_status_s;

    // conversion sequencer states
    typedef enum logic [1:0] {
        CV_HOLD,
        CV_CONV,
        CV_IDLE
    } cvs_conv_e;

endpackage

// [src/cvs_converter_ctrl.sv]
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`include "cvs_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module cvs_converter_ctrl (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [`CVS_AW-1:0]     s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output var  logic                   s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output var  logic                   s_axi_wready,
    output var  logic [1:0]             s_axi_bresp,
    output var  logic                   s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [`CVS_AW-1:0]     s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output var  logic                   s_axi_arready,
    output var  logic [31:0]            s_axi_rdata,
    output var  logic [1:0]             s_axi_rresp,
    output var  logic                   s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic                   sync_n_pin,
    input  wire logic                   reset_n_pin,
    input  wire logic                   standby_n_pin,
    input  wire logic [`CVS_DATA_W-1:0] sample_in,
    output var  logic                   rdy_n_pin,
    output var  logic [1:0]             port_out,
    output var  logic                   mclk_out
);

    localparam logic [`CVS_CNT_W-1:0] SETTLE_CYC = `CVS_CNT_W'(`CVS_SETTLE_CYC);
    localparam logic [`CVS_CNT_W-1:0] UPDATE_CYC = `CVS_CNT_W'(`CVS_UPDATE_CYC);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [2:0] meta_q;
    logic [2:0] pin_q;
    logic [2:0] pin_d1_q;
    logic       sync_rise;
    logic       hw_rst;
    logic       filt_rst;
    logic       standby_flag_act;

    // bit 0 sync, bit 1 reset, bit 2 standby; idle level is high
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q   <= 3'h7;
            pin_q    <= 3'h7;
            pin_d1_q <= 3'h7;
        end else begin
            meta_q   <= {standby_n_pin, reset_n_pin, sync_n_pin};
            pin_q    <= meta_q;
            pin_d1_q <= pin_q;
        end
    end

    // edges are taken from the second and third stages, never the first
    assign sync_rise = pin_q[0] & ~pin_d1_q[0];
    assign hw_rst    = ~pin_q[1];
    // a low sync level holds the filter, so the falling edge is covered too
    assign filt_rst  = ~pin_q[0] | hw_rst;

    // ****************************************
    // bus slave channel state
    // ****************************************
    logic               aw_hold_q;
    logic               w_hold_q;
    logic [`CVS_AW-1:0] aw_addr_q;
    logic [31:0]        w_data_q;
    logic [3:0]         w_strb_q;
    logic               aw_take;
    logic               w_take;
    logic               ar_take;
    logic               do_write;
    logic               aw_hold_d;
    logic               w_hold_d;
    logic               bvalid_d;
    logic               rvalid_d;

    logic               comm_seen_q;
    logic               access_ok;
    logic               rd_ok;
    logic               mode_wr;
    logic               start_req;
    logic               data_read;
    logic [31:0]        rd_val;
    logic [1:0]         rd_resp;
    logic [1:0]         wr_resp;

    cvs_pkg::cvs_mode_s   mode_q;
    cvs_pkg::cvs_mode_s   mode_new;
    cvs_pkg::cvs_status_s status;
    logic [`CVS_DATA_W-1:0] data_q;
    logic                 rdy_n_q;
    logic                 settled_n_q;

    assign aw_take   = s_axi_awvalid & s_axi_awready;
    assign w_take    = s_axi_wvalid & s_axi_wready;
    assign ar_take   = s_axi_arvalid & s_axi_arready;
    assign do_write  = aw_hold_q & w_hold_q & ~s_axi_bvalid;
    assign aw_hold_d = (aw_hold_q | aw_take) & ~do_write;
    assign w_hold_d  = (w_hold_q | w_take) & ~do_write;
    assign bvalid_d  = do_write | (s_axi_bvalid & ~s_axi_bready);
    assign rvalid_d  = ar_take | (s_axi_rvalid & ~s_axi_rready);

    // address and data are caught independently, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q     <= 1'b0;
            w_hold_q      <= 1'b0;
            aw_addr_q     <= '0;
            w_data_q      <= 32'h00000000;
            w_strb_q      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
        end else begin
            aw_hold_q     <= aw_hold_d;
            w_hold_q      <= w_hold_d;
            s_axi_awready <= ~aw_hold_d & ~bvalid_d;
            s_axi_wready  <= ~w_hold_d & ~bvalid_d;
            s_axi_bvalid  <= bvalid_d;
            if (aw_take) begin
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
        end
    end

    // write response code, registered with bvalid
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bresp <= `CVS_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bresp <= wr_resp;
        end
    end

    // ****************************************
    // address decode
    // ****************************************
    // while the reset pin is low every access is answered but has no effect
    assign access_ok = ~hw_rst & comm_seen_q;
    assign mode_new  = cvs_pkg::cvs_mode_s'(w_data_q[`CVS_MODE_W-1:0]);
    assign mode_wr   = do_write & access_ok & w_strb_q[0] &
                       (aw_addr_q == `CVS_OFF_MODE);
    assign start_req = mode_wr & ((mode_new.op_mode == `CVS_MD_CONT) |
                                  (mode_new.op_mode == `CVS_MD_SINGLE));
    assign rd_ok     = ~hw_rst & comm_seen_q;
    assign data_read = ar_take & rd_ok & (s_axi_araddr == `CVS_OFF_DATA);

    // unknown write addresses get an error, read-only ones are dropped quietly
    always_comb begin
        if (aw_addr_q == `CVS_OFF_COMM) begin
            wr_resp = `CVS_RESP_OKAY;
        end else if (aw_addr_q == `CVS_OFF_MODE) begin
            wr_resp = `CVS_RESP_OKAY;
        end else if (aw_addr_q == `CVS_OFF_STATUS) begin
            wr_resp = `CVS_RESP_OKAY;
        end else if (aw_addr_q == `CVS_OFF_DATA) begin
            wr_resp = `CVS_RESP_OKAY;
        end else begin
            wr_resp = `CVS_RESP_SLVERR;
        end
    end

    // read mux; registers stay readable in standby
    always_comb begin
        rd_val  = 32'h00000000;
        rd_resp = `CVS_RESP_OKAY;
        if (s_axi_araddr == `CVS_OFF_COMM) begin
            rd_val = 32'h00000000;
        end else if (s_axi_araddr == `CVS_OFF_MODE) begin
            if (rd_ok) begin
                rd_val = {25'h0000000, mode_q};
            end
        end else if (s_axi_araddr == `CVS_OFF_STATUS) begin
            if (rd_ok) begin
                rd_val = {28'h0000000, status};
            end
        end else if (s_axi_araddr == `CVS_OFF_DATA) begin
            if (rd_ok) begin
                rd_val = {8'h00, data_q};
            end
        end else begin
            rd_resp = `CVS_RESP_SLVERR;
        end
    end

    // read channel: one read in flight, answer one edge after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `CVS_RESP_OKAY;
        end else begin
            s_axi_arready <= ~rvalid_d;
            s_axi_rvalid  <= rvalid_d;
            if (ar_take) begin
                s_axi_rdata <= rd_val;
                s_axi_rresp <= rd_resp;
            end
        end
    end

    // the command register must be written before anything else is reached
    always_ff @(posedge aclk) begin
        if (!aresetn || hw_rst) begin
            comm_seen_q <= 1'b0;
        end else if (do_write && aw_addr_q == `CVS_OFF_COMM) begin
            comm_seen_q <= 1'b1;
        end
    end

    // ****************************************
    // conversion sequencer
    // ****************************************
    cvs_pkg::cvs_conv_e     state_q;
    logic [`CVS_CNT_W-1:0]  cnt_q;
    logic [`CVS_CNT_W-1:0]  total_q;
    logic [`CVS_CNT_W-1:0]  period;
    logic                   first_q;
    logic                   one_shot_q;
    logic                   single_run;
    logic                   quick_single;
    logic                   word_due;
    logic                   settled_now;
    logic                   finish;

    assign standby_flag_act     = ~pin_q[2] | (mode_q.op_mode == `CVS_MD_STANDBY);
    assign single_run   = (mode_q.op_mode == `CVS_MD_SINGLE) | one_shot_q;
    assign quick_single = single_run & mode_q.quick_settle;
    // in single runs, quick settle emits early words at the update rate while settling
    assign period       = (first_q && !quick_single) ? SETTLE_CYC : UPDATE_CYC;
    assign word_due     = (state_q == cvs_pkg::CV_CONV) & ~filt_rst & ~standby_flag_act &
                          ~start_req & (cnt_q == period - 1'b1);
    assign settled_now  = (total_q >= SETTLE_CYC - 1'b1);
    assign finish       = word_due & single_run &
                          (~mode_q.quick_settle | settled_now);

    // counts are restarted from the synced sync level, so every device
    // sharing clock and sync lines steps in lock to within one clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q    <= cvs_pkg::CV_HOLD;
            cnt_q      <= '0;
            total_q    <= '0;
            first_q    <= 1'b1;
            one_shot_q <= 1'b0;
        end else if (filt_rst) begin
            state_q    <= cvs_pkg::CV_HOLD;
            cnt_q      <= '0;
            total_q    <= '0;
            first_q    <= 1'b1;
            one_shot_q <= hw_rst ? 1'b0 : one_shot_q;
        end else if (standby_flag_act) begin
            // frozen in place so leaving standby resumes where it stopped
            state_q    <= state_q;
        end else if (start_req) begin
            state_q    <= cvs_pkg::CV_CONV;
            cnt_q      <= '0;
            total_q    <= '0;
            first_q    <= 1'b1;
            one_shot_q <= 1'b0;
        end else begin
            case (state_q)
                cvs_pkg::CV_HOLD: begin
                    // release from reset starts gathering on this edge
                    state_q    <= cvs_pkg::CV_CONV;
                    cnt_q      <= '0;
                    total_q    <= '0;
                    first_q    <= 1'b1;
                    one_shot_q <= (mode_q.op_mode == `CVS_MD_IDLE);
                end
                cvs_pkg::CV_CONV: begin
                    if (mode_q.op_mode == `CVS_MD_IDLE && !one_shot_q) begin
                        state_q <= cvs_pkg::CV_IDLE;
                    end else if (finish) begin
                        state_q    <= cvs_pkg::CV_IDLE;
                        one_shot_q <= 1'b0;
                    end
                    cnt_q <= word_due ? '0 : cnt_q + 1'b1;
                    if (!settled_now) begin
                        total_q <= total_q + 1'b1;
                    end
                    if (word_due) begin
                        first_q <= 1'b0;
                    end
                end
                cvs_pkg::CV_IDLE: begin
                    state_q <= cvs_pkg::CV_IDLE;
                end
                default: begin
                    state_q <= cvs_pkg::CV_HOLD;
                end
            endcase
        end
    end

    // ****************************************
    // registers and indicators
    // ****************************************
    // bus write beats the automatic return to idle in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn || hw_rst) begin
            mode_q <= cvs_pkg::cvs_mode_s'(`CVS_MODE_RST);
        end else if (mode_wr) begin
            mode_q <= mode_new;
        end else if (finish && mode_q.op_mode == `CVS_MD_SINGLE) begin
            mode_q.op_mode <= `CVS_MD_IDLE;
        end
    end

    // data word; sync leaves it alone, only the reset pin clears it
    always_ff @(posedge aclk) begin
        if (!aresetn || hw_rst) begin
            data_q <= `CVS_DATA_RST;
        end else if (word_due) begin
            data_q <= sample_in;
        end
    end

    // ready: a new word wins over the clear caused by reading the data
    always_ff @(posedge aclk) begin
        if (!aresetn || hw_rst) begin
            rdy_n_q <= 1'b1;
        end else if (standby_flag_act) begin
            rdy_n_q <= 1'b1;
        end else if (word_due) begin
            rdy_n_q <= 1'b0;
        end else if (data_read) begin
            rdy_n_q <= 1'b1;
        end
    end

    // settled flag drops only on a word produced after full settling
    always_ff @(posedge aclk) begin
        if (!aresetn || hw_rst) begin
            settled_n_q <= 1'b1;
        end else if (standby_flag_act || filt_rst || start_req) begin
            settled_n_q <= 1'b1;
        end else if (word_due && settled_now) begin
            settled_n_q <= 1'b0;
        end
    end

    assign status.ready_n          = rdy_n_q;
    assign status.filter_settled_n = settled_n_q;
    assign status.standby_flag     = standby_flag_act;
    assign status.in_reset         = filt_rst;
    assign rdy_n_pin               = rdy_n_q;

    // ****************************************
    // port pins and clock output
    // ****************************************
    // port pins read low while the output enable is clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_out <= 2'h0;
        end else if (mode_q.port_output_enable) begin
            port_out <= {mode_q.port_out_bit1, mode_q.port_out_bit0};
        end else begin
            port_out <= 2'h0;
        end
    end

    // divided copy of the clock; ignores reset pin and standby on purpose
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mclk_out <= 1'b0;
        end else begin
            mclk_out <= ~mclk_out;
        end
    end

endmodule

`default_nettype wire

// [bench/cvs_converter_ctrl_props.sv]
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// port checker
// ****************************************
module cvs_converter_ctrl_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sync_n_pin,
    input wire logic reset_n_pin,
    input wire logic standby_n_pin,
    input wire logic rdy_n_pin,
    input wire logic mclk_out
);
    logic [11:0] since_q;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // cycles since a pin restart; saturates so it never wraps into a false short count
    always_ff @(posedge aclk) begin
        if (!aresetn || !reset_n_pin || !sync_n_pin) begin
            since_q <= 12'h000;
        end else if (since_q != 12'hfff) begin
            since_q <= since_q + 12'h001;
        end
    end

    // pins and conversion timing
    mclk_runs_a: assert property ($past(aresetn) |-> mclk_out != $past(mclk_out))
        else $error("clock output stopped");
    reset_rdy_a: assert property (!reset_n_pin [*5] |-> rdy_n_pin)
        else $error("ready low during reset pin");
    standby_rdy_a: assert property (!standby_n_pin [*5] |-> rdy_n_pin)
        else $error("ready low during standby");
    sync_hold_a: assert property (!sync_n_pin [*4] |-> !$fell(rdy_n_pin))
        else $error("word produced while sync held low");
    settle_first_a: assert property ($fell(rdy_n_pin) |-> since_q > 12'd499)
        else $error("word before settling time");

    // bus handshakes
    write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
        else $error("write channel not reopened");
    read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read channel not reopened");

    cover property (s_axi_bvalid && s_axi_bready);
    cover property ($fell(rdy_n_pin));
    cover property (!standby_n_pin && s_axi_rvalid);
endmodule

bind cvs_converter_ctrl cvs_converter_ctrl_props u_cvs_converter_ctrl_props (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .sync_n_pin,
    .reset_n_pin, .standby_n_pin, .rdy_n_pin, .mclk_out
);

`default_nettype wire

// [bench/cvs_host_pins.sv]
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// host side: control pins and modulator word
// ****************************************
module cvs_host_pins (
    input  wire logic        aclk,
    output var  logic        sync_n_pin,
    output var  logic        reset_n_pin,
    output var  logic        standby_n_pin,
    output var  logic [23:0] sample_in
);
    // pins idle high so the part starts converting at once
    initial begin
        sync_n_pin = 1'b1;
        reset_n_pin = 1'b1;
        standby_n_pin = 1'b1;
        sample_in = 24'h000000;
    end

    // pins move only just after an edge; the part's own flops absorb the crossing
    task automatic drive(input int pin, input logic v);
        case (pin)
            0: sync_n_pin <= v;
            1: reset_n_pin <= v;
            default: standby_n_pin <= v;
        endcase
    endtask

    task automatic set_word(input logic [23:0] w);
        sample_in <= w;
    endtask
endmodule

`default_nettype wire

// [bench/cvs_converter_ctrl_test.sv]
`include "cvs_defines.svh"
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// testbench
// ****************************************
module cvs_converter_ctrl_test;
    logic                   aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic                   s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid, rdy_n_pin, mclk_out;
    logic                   s_axi_bready, s_axi_rready;
    logic                   sync_n_pin, reset_n_pin, standby_n_pin, m;
    logic [`CVS_AW-1:0]     s_axi_awaddr, s_axi_araddr;
    logic [31:0]            s_axi_wdata, s_axi_rdata, d;
    logic [1:0]             s_axi_bresp, s_axi_rresp, port_out, r;
    logic [`CVS_DATA_W-1:0] sample_in;
    int                     failures, samples_checked, n;

    // strobes tied: only the low byte lane carries a field
    cvs_converter_ctrl u_cvs_converter_ctrl (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .sync_n_pin, .reset_n_pin, .standby_n_pin, .sample_in, .rdy_n_pin, .port_out, .mclk_out
    );
    cvs_host_pins u_cvs_host_pins (.aclk, .sync_n_pin, .reset_n_pin, .standby_n_pin, .sample_in);

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic wrap_up();
        if (failures == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_up(input int k, input int lim);
        if (k >= lim) begin
            failures++;
            wrap_up();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int k;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
            s_axi_bready <= 1'b1;
        end
        s_axi_bready <= 1'b0;
        give_up(k, 40);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
        int k;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
            s_axi_rready <= 1'b1;
        end
        s_axi_rready <= 1'b0;
        v = s_axi_rdata;
        rr = s_axi_rresp;
        give_up(k, 40);
    endtask

    // read and compare in one go; the caller's line carries the tag
    task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string what);
        rd(a, d, r);
        check(what, d, exp);
    endtask

    task automatic wait_rdy(input int lim);
        for (n = 0; n < lim && rdy_n_pin !== 1'b0; n++) @(posedge aclk);
        give_up(n, lim);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic s_boot();
        rc(`CVS_OFF_MODE, 32'h0, "mode before command");
        rd(8'h10, d, r);
        check("unmapped resp", r, `CVS_RESP_SLVERR);
        wr(8'h10, 32'h0);
        check("unmapped write resp", s_axi_bresp, `CVS_RESP_SLVERR);
        wr(`CVS_OFF_COMM, 32'h0);
        check("command write resp", s_axi_bresp, `CVS_RESP_OKAY);
        rc(`CVS_OFF_MODE, 32'h01, "mode default");
        u_cvs_host_pins.set_word(24'h5a5a01);
        wait_rdy(700);
        rc(`CVS_OFF_DATA, 32'h5a5a01, "first word");
    endtask

    task automatic s_sync();
        u_cvs_host_pins.drive(0, 1'b0);
        repeat (4) @(posedge aclk);
        rd(`CVS_OFF_DATA, d, r);
        repeat (200) @(posedge aclk);
        check("ready during sync", rdy_n_pin, 1'b1);
        rc(`CVS_OFF_STATUS, 32'hb, "status in sync");
        rc(`CVS_OFF_MODE, 32'h01, "mode kept by sync");
        u_cvs_host_pins.set_word(24'hc3c302);
        u_cvs_host_pins.drive(0, 1'b1);
        wait_rdy(700);
        check("sync settle", n >= 500 && n <= 506, 1'b1);
        rc(`CVS_OFF_DATA, 32'hc3c302, "sync word");
    endtask

    task automatic s_single();
        wr(`CVS_OFF_MODE, 32'h02);
        rd(`CVS_OFF_DATA, d, r);
        wait_rdy(700);
        check("single settle", n >= 490 && n <= 506, 1'b1);
        rc(`CVS_OFF_MODE, 32'h00, "single back to idle");
        rd(`CVS_OFF_DATA, d, r);
        u_cvs_host_pins.drive(0, 1'b0);
        repeat (4) @(posedge aclk);
        u_cvs_host_pins.drive(0, 1'b1);
        wait_rdy(700);
        rd(`CVS_OFF_DATA, d, r);
        wr(`CVS_OFF_MODE, 32'h0a);
        wait_rdy(150);
        check("quick first word", n >= 90 && n <= 110, 1'b1);
        rc(`CVS_OFF_STATUS, 32'h2, "quick unsettled");
        repeat (500) @(posedge aclk);
        rc(`CVS_OFF_MODE, 32'h08, "quick back to idle");
        rc(`CVS_OFF_DATA, 32'hc3c302, "quick last word");
    endtask

    task automatic s_standby();
        wr(`CVS_OFF_MODE, 32'h01);
        wait_rdy(700);
        u_cvs_host_pins.drive(2, 1'b0);
        repeat (4) @(posedge aclk);
        rc(`CVS_OFF_STATUS, 32'h7, "standby status");
        rc(`CVS_OFF_DATA, 32'h0a5a5a, "data kept");
        u_cvs_host_pins.drive(2, 1'b1);
        repeat (4) @(posedge aclk);
        rc(`CVS_OFF_STATUS, 32'h3, "after standby");
        wait_rdy(700);
        wr(`CVS_OFF_MODE, 32'h03);
        rc(`CVS_OFF_STATUS, 32'h7, "mode standby");
    endtask

    task automatic s_ports();
        for (int i = 0; i < 5; i++) begin
            wr(`CVS_OFF_MODE, (i < 4) ? 32'h10 | (i << 5) : 32'h60);
            repeat (3) @(posedge aclk);
            check("port pins", port_out, (i < 4) ? i[1:0] : 2'h0);
        end
    endtask

    task automatic s_reset_pin();
        u_cvs_host_pins.drive(1, 1'b0);
        repeat (5) @(posedge aclk);
        check("ready in reset", rdy_n_pin, 1'b1);
        m = mclk_out;
        @(posedge aclk);
        check("clock out runs", mclk_out, !m);
        wr(`CVS_OFF_MODE, 32'h02);
        u_cvs_host_pins.drive(1, 1'b1);
        repeat (3) @(posedge aclk);
        rc(`CVS_OFF_MODE, 32'h0, "mode before command");
        wr(`CVS_OFF_COMM, 32'h0);
        rc(`CVS_OFF_MODE, 32'h01, "mode reloaded");
        rc(`CVS_OFF_DATA, 32'h0, "data cleared");
        wait_rdy(700);
    endtask

    initial begin
        aresetn = 1'b0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_rready = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        s_boot();
        s_sync();
        s_single();
        u_cvs_host_pins.set_word(24'h0a5a5a);
        s_standby();
        s_ports();
        s_reset_pin();
        wrap_up();
    end
endmodule

`default_nettype wire
